//--- sspc_defines.vh
/*
  constants for the sync serial port control block: register offsets,
  control field positions, reset value, word and frame sizes.
  assumes inclusion by bare name from the design file.
*/
`ifndef SSPC_DEFINES_VH
`define SSPC_DEFINES_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SSPC_CTL_OFFSET    12'h000
`define SSPC_STAT_OFFSET   12'h004
`define SSPC_TXDATA_OFFSET 12'h008
`define SSPC_RXDATA_OFFSET 12'h00C
`define SSPC_CTL_RESET     32'h00F00000

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define SSPC_TX_SOFT_RESET   31
`define SSPC_RX_SOFT_RESET   30
`define SSPC_TX_ENABLE       29
`define SSPC_RX_ENABLE       28
`define SSPC_TX_EDGE_SEL     27
`define SSPC_RX_EDGE_SEL     26
`define SSPC_TX_ORDER        25
`define SSPC_RX_ORDER        24
`define SSPC_AUX1_FN_HI      23
`define SSPC_AUX1_FN_LO      22
`define SSPC_AUX2_FN_HI      21
`define SSPC_AUX2_FN_LO      20
`define SSPC_AUX1_OUT        19
`define SSPC_AUX2_OUT        18
`define SSPC_TX_IRQ_EN       17
`define SSPC_RX_IRQ_EN       16
`define SSPC_SLOT_HI         15
`define SSPC_SLOT_LO         12
`define SSPC_CTL_RW_MASK     32'h3FFFF000

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define SSPC_ST_TX_EMPTY     0
`define SSPC_ST_TX_UNDERRUN  1
`define SSPC_ST_TX_FRAMING   2
`define SSPC_ST_RX_FULL      3
`define SSPC_ST_RX_OVERRUN   4
`define SSPC_ST_RX_FRAMING   5

// ----------------------------------------------------------------------
// sizes and codes
// ----------------------------------------------------------------------
`define SSPC_WORD_BITS       16
`define SSPC_BIT_CNT_W       4
`define SSPC_BIT_LAST        4'hF
`define SSPC_SLOT_ZERO       4'h0
`define SSPC_AUX_FN_GPO      2'h1
`define SSPC_HTRANS_NONSEQ   2'h2

`endif

//--- sspc_top.v
/*
  sync serial port control: ahb-lite slave with the control register,
  a status register and 16-bit data registers, plus the bit-level
  transmit and receive shifters and the frame sync divider.
  assumes tx/rx bit clocks and serial input arrive asynchronously and are
  far slower than hclk; sole slave, single word transfers.
*/
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "sspc_defines.vh"

module sspc_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        tx_bit_clock,
  input  wire        rx_bit_clock,
  input  wire        serial_in_pin,
  output reg         frame_sync_out,
  output reg         serial_out_pin,
  output reg         serial_out_oe,
  output reg         aux_pin1_out,
  output reg         aux_pin1_oe,
  output reg         aux_pin2_out,
  output reg         aux_pin2_oe,
  output reg         irq_req
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // edge pick: sel one means falling edge of the synchronised clock
  function edge_hit;
    input sel;
    input cur;
    input prev;
    begin
      edge_hit = sel ? (prev & ~cur) : (cur & ~prev);
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg [2:0] txc_sync_reg;
  reg [2:0] rxc_sync_reg;
  reg [1:0] sin_sync_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txc_sync_reg <= 3'h0;
      rxc_sync_reg <= 3'h0;
      sin_sync_reg <= 2'h0;
    end else begin
      txc_sync_reg <= {txc_sync_reg[1:0], tx_bit_clock};
      rxc_sync_reg <= {rxc_sync_reg[1:0], rx_bit_clock};
      sin_sync_reg <= {sin_sync_reg[0], serial_in_pin};
    end
  end

  // ----------------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------------
  reg        ph_wr_reg;
  reg        ph_rd_reg;
  reg [11:0] ph_addr_reg;
  wire       ahb_go = hsel & hready & (htrans == `SSPC_HTRANS_NONSEQ);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg   <= 1'b0;
      ph_rd_reg   <= 1'b0;
      ph_addr_reg <= 12'h000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      ph_wr_reg   <= ahb_go & hwrite;
      ph_rd_reg   <= ahb_go & ~hwrite;
      ph_addr_reg <= haddr[11:0];
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  wire wr_ctl  = ph_wr_reg & (ph_addr_reg == `SSPC_CTL_OFFSET);
  wire wr_tx   = ph_wr_reg & (ph_addr_reg == `SSPC_TXDATA_OFFSET);
  wire rd_rx_a = ahb_go & ~hwrite & (haddr[11:0] == `SSPC_RXDATA_OFFSET);
  wire rd_st_a = ahb_go & ~hwrite & (haddr[11:0] == `SSPC_STAT_OFFSET);
  wire soft_rst = wr_ctl & hwdata[`SSPC_TX_SOFT_RESET] & hwdata[`SSPC_RX_SOFT_RESET];
  wire tx_rst   = wr_ctl & hwdata[`SSPC_TX_SOFT_RESET] | soft_rst;
  wire rx_rst   = wr_ctl & hwdata[`SSPC_RX_SOFT_RESET] | soft_rst;

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  reg [31:0] ctl_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctl_reg <= `SSPC_CTL_RESET;
    else if (wr_ctl)
      ctl_reg <= hwdata & `SSPC_CTL_RW_MASK;
  end

  wire       tx_en    = ctl_reg[`SSPC_TX_ENABLE];
  wire       rx_en    = ctl_reg[`SSPC_RX_ENABLE];
  wire [3:0] slot_cnt = ctl_reg[`SSPC_SLOT_HI:`SSPC_SLOT_LO];
  wire [1:0] aux1_fn  = ctl_reg[`SSPC_AUX1_FN_HI:`SSPC_AUX1_FN_LO];
  wire [1:0] aux2_fn  = ctl_reg[`SSPC_AUX2_FN_HI:`SSPC_AUX2_FN_LO];

  wire tx_tick = edge_hit(ctl_reg[`SSPC_TX_EDGE_SEL], txc_sync_reg[1], txc_sync_reg[2]);
  wire rx_tick = edge_hit(~ctl_reg[`SSPC_RX_EDGE_SEL], rxc_sync_reg[1], rxc_sync_reg[2]);

  // ----------------------------------------------------------------------
  // frame sync divider, counted in words on the tx bit clock
  // ----------------------------------------------------------------------
  reg [3:0] bitpos_reg;
  reg [3:0] slot_reg;
  wire      word_end  = tx_tick & (bitpos_reg == `SSPC_BIT_LAST);
  wire [3:0] slot_last = slot_cnt - 4'h1; // zero wraps to sixteen slots
  wire      frame_now = word_end & (slot_reg == slot_last);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bitpos_reg     <= 4'h0;
      slot_reg       <= 4'h0;
      frame_sync_out <= 1'b0;
    end else if (tx_rst) begin
      bitpos_reg     <= 4'h0;
      slot_reg       <= 4'h0;
      frame_sync_out <= 1'b0;
    end else begin
      if (tx_tick)
        bitpos_reg <= bitpos_reg + 4'h1;
      if (word_end)
        slot_reg <= frame_now ? `SSPC_SLOT_ZERO : slot_reg + 4'h1;
      if (tx_tick)
        frame_sync_out <= (bitpos_reg == `SSPC_BIT_LAST) & (slot_reg == slot_last);
    end
  end

  // ----------------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------------
  reg [15:0] tx_data_reg;
  reg [15:0] tx_shift_reg;
  reg        tx_full_reg;
  reg        tx_active_reg;
  reg        tx_empty_reg;
  reg        tx_under_reg;
  reg        tx_frm_reg;
  wire       tx_order = ctl_reg[`SSPC_TX_ORDER];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data_reg    <= 16'h0000;
      tx_shift_reg   <= 16'h0000;
      tx_full_reg    <= 1'b0;
      tx_active_reg  <= 1'b0;
      tx_empty_reg   <= 1'b0;
      tx_under_reg   <= 1'b0;
      tx_frm_reg     <= 1'b0;
      serial_out_pin <= 1'b0;
      serial_out_oe  <= 1'b0;
    end else if (tx_rst) begin // data word itself is kept
      tx_shift_reg   <= 16'h0000;
      tx_full_reg    <= 1'b0;
      tx_active_reg  <= 1'b0;
      tx_empty_reg   <= 1'b0;
      tx_under_reg   <= 1'b0;
      tx_frm_reg     <= 1'b0;
      serial_out_oe  <= 1'b0;
    end else begin
      if (wr_tx) begin // writes accepted while disabled
        tx_data_reg <= hwdata[15:0];
        tx_full_reg <= 1'b1;
      end
      if (tx_tick & tx_active_reg) begin
        serial_out_pin <= tx_order ? tx_shift_reg[0] : tx_shift_reg[15];
        serial_out_oe  <= 1'b1;
        tx_shift_reg   <= tx_order ? {1'b0, tx_shift_reg[15:1]} : {tx_shift_reg[14:0], 1'b0};
      end
      // last bit stays driven for its full bit time before release
      if (tx_tick & ~tx_active_reg)
        serial_out_oe <= 1'b0;
      // word boundary: load next word only while enabled
      if (word_end) begin
        if (tx_en & (tx_active_reg | frame_now)) begin
          tx_active_reg <= 1'b1;
          tx_shift_reg  <= tx_full_reg ? tx_data_reg : 16'h0000;
          if (!(wr_tx))
            tx_full_reg <= 1'b0;
          tx_empty_reg  <= 1'b1;
          if (!tx_full_reg)
            tx_under_reg <= 1'b1;
        end else begin
          tx_active_reg <= 1'b0; // status left untouched
        end
      end
      if (wr_tx & ~word_end)
        tx_empty_reg <= 1'b0;
      if (rd_st_a & ~word_end) begin
        tx_under_reg <= 1'b0;
        tx_frm_reg   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  reg [15:0] rx_shift_reg;
  reg [15:0] rx_data_reg;
  reg [3:0]  rx_cnt_reg;
  reg        rx_active_reg;
  reg        rx_full_reg;
  reg        rx_over_reg;
  reg        rx_frm_reg;
  wire       rx_order = ctl_reg[`SSPC_RX_ORDER];
  wire       rx_bit   = sin_sync_reg[1];
  wire       rx_done  = rx_tick & rx_active_reg & (rx_cnt_reg == `SSPC_BIT_LAST);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_shift_reg  <= 16'h0000;
      rx_data_reg   <= 16'h0000;
      rx_cnt_reg    <= 4'h0;
      rx_active_reg <= 1'b0;
      rx_full_reg   <= 1'b0;
      rx_over_reg   <= 1'b0;
      rx_frm_reg    <= 1'b0;
    end else if (rx_rst) begin // data word itself is kept
      rx_shift_reg  <= 16'h0000;
      rx_cnt_reg    <= 4'h0;
      rx_active_reg <= 1'b0;
      rx_full_reg   <= 1'b0;
      rx_over_reg   <= 1'b0;
      rx_frm_reg    <= 1'b0;
    end else begin
      // sync marks the bit before the word: first sample on the next edge
      if (rx_tick & ~rx_active_reg & rx_en & frame_sync_out) begin
        rx_active_reg <= 1'b1;
      end else if (rx_tick & rx_active_reg) begin
        rx_cnt_reg    <= rx_cnt_reg + 4'h1;
        rx_shift_reg  <= rx_order ? {rx_bit, rx_shift_reg[15:1]}
                                  : {rx_shift_reg[14:0], rx_bit};
      end
      if (rx_done) begin // word finished even if disabled meanwhile
        rx_data_reg   <= rx_order ? {rx_bit, rx_shift_reg[15:1]} : {rx_shift_reg[14:0], rx_bit};
        rx_full_reg   <= 1'b1;
        rx_active_reg <= rx_en;
        if (rx_full_reg)
          rx_over_reg <= 1'b1;
      end else begin
        if (rd_rx_a)
          rx_full_reg <= 1'b0;
        if (rd_st_a) begin
          rx_over_reg <= 1'b0;
          rx_frm_reg  <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data, aux pins, interrupt request
  // ----------------------------------------------------------------------
  wire [31:0] stat_word = {26'h0000000, rx_frm_reg, rx_over_reg, rx_full_reg,
                           tx_frm_reg, tx_under_reg, tx_empty_reg};
  wire tx_irq = ctl_reg[`SSPC_TX_IRQ_EN] & (tx_empty_reg | tx_under_reg | tx_frm_reg);
  wire rx_irq = ctl_reg[`SSPC_RX_IRQ_EN] & (rx_full_reg | rx_over_reg | rx_frm_reg);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata       <= 32'h00000000;
      aux_pin1_out <= 1'b0;
      aux_pin1_oe  <= 1'b0;
      aux_pin2_out <= 1'b0;
      aux_pin2_oe  <= 1'b0;
      irq_req      <= 1'b0;
    end else begin
      if (ahb_go & ~hwrite) begin
        case (haddr[11:0])
          `SSPC_CTL_OFFSET:    hrdata <= ctl_reg;
          `SSPC_STAT_OFFSET:   hrdata <= stat_word;
          `SSPC_RXDATA_OFFSET: hrdata <= {16'h0000, rx_data_reg};
          `SSPC_TXDATA_OFFSET: hrdata <= {16'h0000, tx_data_reg};
          default:             hrdata <= 32'h00000000;
        endcase
      end
      aux_pin1_oe  <= (aux1_fn == `SSPC_AUX_FN_GPO);
      aux_pin1_out <= ctl_reg[`SSPC_AUX1_OUT];
      aux_pin2_oe  <= (aux2_fn == `SSPC_AUX_FN_GPO);
      aux_pin2_out <= ctl_reg[`SSPC_AUX2_OUT];
      irq_req      <= tx_irq | rx_irq;
    end
  end

endmodule

//--- sspc_chk.sv
/*
  checker for sspc_top: bus answers, control readback, aux pins, irq gate.
  assumes bind to sspc_top and a control shadow built from bus writes.
*/
`timescale 1ns/1ns
module sspc_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        aux_pin1_out,
  input wire        aux_pin1_oe,
  input wire        aux_pin2_out,
  input wire        aux_pin2_oe,
  input wire        irq_req
);
  reg        wr_reg;
  reg [31:0] sh_reg;
  reg [1:0]  age_reg;
  wire       ok;
  wire       addr_ok;
  assign addr_ok = hsel && hready && htrans == 2'h2 && haddr[11:0] == 12'h000;
  assign ok      = age_reg == 2'h3;
  // shadow of the control register, settled three cycles after a write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg  <= 1'b0;
      sh_reg  <= 32'h00F00000;
      age_reg <= 2'h0;
    end else begin
      wr_reg  <= addr_ok && hwrite;
      sh_reg  <= wr_reg ? (hwdata & 32'h3FFFF000) : sh_reg;
      age_reg <= wr_reg ? 2'h0 : (ok ? age_reg : age_reg + 2'h1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_ctl_read: assert property (addr_ok && !hwrite |=> hrdata == sh_reg)
    else $error("control readback wrong");
  chk_aux1_oe: assert property (ok |-> aux_pin1_oe == (sh_reg[23:22] == 2'h1))
    else $error("aux1 enable wrong");
  chk_aux1_val: assert property (ok && aux_pin1_oe |-> aux_pin1_out == sh_reg[19])
    else $error("aux1 value wrong");
  chk_aux2_oe: assert property (ok |-> aux_pin2_oe == (sh_reg[21:20] == 2'h1))
    else $error("aux2 enable wrong");
  chk_aux2_val: assert property (ok && aux_pin2_oe |-> aux_pin2_out == sh_reg[18])
    else $error("aux2 value wrong");
  chk_irq_gate: assert property (ok && sh_reg[17:16] == 2'h0 |-> !irq_req)
    else $error("irq without enable");
endmodule

//--- sspc_codec.sv
/*
  far side model: free running bit clocks, serial line looped back.
  assumes the port drives serial_out_pin only while serial_out_oe is high.
*/
`timescale 1ns/1ns
module sspc_codec (
  output reg  tx_bit_clock,
  output wire rx_bit_clock,
  output wire serial_in_pin,
  input  wire serial_out_pin,
  input  wire serial_out_oe
);
  reg last_reg;
  initial begin
    last_reg = 1'b0;
    tx_bit_clock = 1'b0;
    #7;
    forever begin
      #62 tx_bit_clock = ~tx_bit_clock;
      #63 tx_bit_clock = ~tx_bit_clock;
    end
  end
  assign rx_bit_clock = tx_bit_clock;
  always @(serial_out_pin or serial_out_oe) begin
    if (serial_out_oe) last_reg = serial_out_pin;
  end
  // a released line shows the inverse of its last level
  assign serial_in_pin = serial_out_oe ? serial_out_pin : ~last_reg;
endmodule

//--- sspc_top_tb.sv
/*
  self-checking bench for sspc_top with a loopback codec model.
  assumes zero wait state ahb-lite slave and the checker bound below.
*/
`timescale 1ns/1ns
module sspc_top_tb;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  wire        hready;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        tx_bit_clock;
  wire        rx_bit_clock;
  wire        serial_in_pin;
  wire        frame_sync_out;
  wire        serial_out_pin;
  wire        serial_out_oe;
  wire        aux_pin1_out;
  wire        aux_pin1_oe;
  wire        aux_pin2_out;
  wire        aux_pin2_oe;
  wire        irq_req;
  integer     mismatches;
  integer     checks;
  integer     i;
  integer     k;
  integer     n;
  reg  [31:0] seed;
  reg  [31:0] v;
  reg  [31:0] rd;
  assign hready = hreadyout;
  sspc_top u_sspc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_bit_clock(tx_bit_clock),
    .rx_bit_clock(rx_bit_clock), .serial_in_pin(serial_in_pin),
    .frame_sync_out(frame_sync_out), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .aux_pin1_out(aux_pin1_out), .aux_pin1_oe(aux_pin1_oe),
    .aux_pin2_out(aux_pin2_out), .aux_pin2_oe(aux_pin2_oe), .irq_req(irq_req));
  sspc_codec u_sspc_codec (.tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe));
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] rev(input [15:0] x);
    integer j;
    begin
      rev = 32'h00000000;
      for (j = 0; j < 16; j = j + 1) rev[j] = x[15 - j];
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task report_and_stop;
    begin
      $display("counts: %0d mismatches, %0d checks", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #400000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
    mismatches = 0;
    checks = 0;
    seed = 32'h00000031;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, 12'h000, 0);
    chk(rd, 32'h00F00000);
    xfer(0, 12'h010, 0);
    chk(rd, 0);
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      xfer(1, 12'h000, seed & 32'h3FFFFFFF);
      xfer(0, 12'h000, 0);
      chk(rd, seed & 32'h3FFFF000);
    end
    xfer(1, 12'h000, 32'hC0F00000);
    xfer(0, 12'h000, 0);
    chk(rd, 32'h00F00000);
    $display("register test done");
    for (i = 0; i < 8; i = i + 1) begin
      xfer(1, 12'h000, {8'h00, i[1:0], ~i[1:0], i[2], ~i[2], 18'h00000});
      repeat (4) @(posedge hclk);
      chk({aux_pin1_oe, aux_pin2_oe}, {i[1:0] == 2'h1, ~i[1:0] == 2'h1});
      chk({aux_pin1_oe & aux_pin1_out, aux_pin2_oe & aux_pin2_out},
          {i[1:0] == 2'h1 & i[2], ~i[1:0] == 2'h1 & ~i[2]});
    end
    $display("aux pin test done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      v = {16'h0000, seed[15:0]};
      xfer(1, 12'h000, 32'hC0F00000);
      xfer(1, 12'h000, {4'h3, i[1], i[1], i[0], i[1], 8'hF0, 4'h1, 12'h000});
      for (k = 0; k < 3; k = k + 1) begin
        xfer(1, 12'h008, v);
        n = 0;
        rd = 0;
        while (rd[3] !== 1'b1 && n < 400) begin
          xfer(0, 12'h004, 0);
          n = n + 1;
        end
        chk(n < 400, 1);
        xfer(0, 12'h00C, 0);
      end
      chk(rd, (i[0] == i[1]) ? v : rev(v[15:0]));
    end
    $display("loopback test done");
    xfer(1, 12'h000, 32'h10F01000);
    n = 0;
    while (serial_out_oe !== 1'b0 && n < 400) begin
      @(posedge hclk);
      n = n + 1;
    end
    repeat (300) @(posedge hclk);
    chk(serial_out_oe, 0);
    $display("tx disable test done");
    for (k = 0; k < 2; k = k + 1) begin
      xfer(1, 12'h000, 32'h30F01000 | (32'h00010000 << k));
      xfer(1, 12'h008, v);
      n = 0;
      while (irq_req !== 1'b1 && n < 1000) begin
        @(posedge hclk);
        n = n + 1;
      end
      chk(irq_req, 1);
      xfer(1, 12'h000, 32'h30F01000);
      repeat (4) @(posedge hclk);
      chk(irq_req, 0);
    end
    $display("irq test done");
    // frame period: slots of 16 bits at 125 ns, field zero meaning 16 slots
    for (k = 0; k < 2; k = k + 1) begin
      xfer(1, 12'h000, 32'h00F00000 | (k << 13));
      @(posedge frame_sync_out);
      @(posedge frame_sync_out);
      v = $time;
      @(posedge frame_sync_out);
      chk($time - v, k ? 32'h00000FA0 : 32'h00007D00);
    end
    $display("frame size test done");
    report_and_stop;
  end
endmodule
bind sspc_top sspc_chk u_sspc_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .aux_pin1_out(aux_pin1_out),
  .aux_pin1_oe(aux_pin1_oe), .aux_pin2_out(aux_pin2_out), .aux_pin2_oe(aux_pin2_oe),
  .irq_req(irq_req));
